// ==== rtl/flash_status_write_protect.sv ====
// Status register and write protection of a serial NOR flash.
// Assumes a command decoder on clk_sys hands over decoded commands as
// one-cycle pulses; pins (write protect, link clock) are asynchronous.
// Assumes the non-volatile image is valid in the first cycle after reset
// and that the store port writes it back before the next power cycle.
// Behaviour
// - Sixteen-bit status word with busy, latch, protect, mode, quad, lock.
// - Busy bit reads one during program, erase or status write.
// - Latch clear refuses status write, program and erase.
// - Protect bits persist; only a status write changes them, unless locked.
// - Program and erase refused inside the selected protected range.
// - Whole-array clear only with protect bits 2-0 and complement zero.
// - Complement bit 14 persists, default zero, joins the protect decode.
// - Complement one protects the inverse of the normal range.
// - Mode 01 locks status writes while write protect pin is low and quad enable is clear.
// - Mode 00 allows status writes once latch set, pin ignored.
// - Mode 10 refuses status writes until power cycle, which restores 00.
// - Mode 11 refuses all status writes permanently.
// - Mode bits persist across power cycles except mode 10.
// - Quad enable persists, default zero, frees pins for quad data.
// - Security lock is one-time: once set never clears.
// - Complement zero: code 000 protects nothing, x11x protects all.
// - Latch clears at power-up, disable, status write, program, erase.
// - Write protect pin low guards protect and mode bits in mode 01 with quad clear.
// - Quad commands run only with quad enable set.
`timescale 1ns/1ps
`include "flash_sr_cfg.svh"
module flash_status_write_protect #(
  parameter int ADDR_W   = 21,
  parameter int BUSY_CYC = `OP_BUSY_CYC
) (
  // System
  input  wire logic                 clk_sys,
  input  wire logic                 resetn,
  // Non-volatile image loaded at power-up, stored back on update
  input  wire logic [15:0]          nv_image,
  output logic      [15:0]          nv_store,
  output logic                      nv_store_en,
  // Pins
  input  wire logic                 write_protect_pin_in,
  input  wire logic                 link_clk,
  // Decoded command from the framing logic
  input  wire logic                 cmd_valid,
  input  wire flash_sr_pkg::cmd_t   cmd_code,
  input  wire logic [ADDR_W-1:0]    cmd_addr,
  input  wire logic [15:0]          cmd_data,
  input  wire logic                 high_perf_in,
  input  wire logic                 op_paused_in,
  // Results
  output logic [15:0]               status_word,
  output logic                      cmd_accepted,
  output logic                      cmd_rejected,
  output logic                      array_op_start,
  output logic                      quad_mode,
  output logic                      security_ro,
  output logic                      link_clk_rise
);

  // Elaboration checks: the range decode reads 21 address bits and the
  // busy counter is 16 bits wide, so narrower addresses, a zero busy
  // length or a longer one cannot be served
  if (ADDR_W < 21) begin : g_addr_check
    $error("flash_status_write_protect: ADDR_W below 21");
  end
  if (BUSY_CYC < 1 || BUSY_CYC > 65536) begin : g_busy_check
    $error("flash_status_write_protect: BUSY_CYC out of range");
  end

  // Pin synchronisers: first stage only feeds the second
  logic [1:0] wp_sync_r, wp_sync_nxt;
  logic [2:0] lclk_sync_r, lclk_sync_nxt;
  always_comb begin
    wp_sync_nxt   = {wp_sync_r[0], write_protect_pin_in};
    lclk_sync_nxt = {lclk_sync_r[1:0], link_clk};
  end
  // Reset values match the idle pin levels, so no false edge follows
  // reset; the third link stage only serves the edge detector
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wp_sync_r   <= 2'b11;
      lclk_sync_r <= 3'b000;
    end else begin
      wp_sync_r   <= wp_sync_nxt;
      lclk_sync_r <= lclk_sync_nxt;
    end
  end

  // Protected-range decode over the 2 MB array. The plain range is worked
  // out first and the complement bit inverts it, so both tables share one
  // decoder; address bits above 20 are ignored
  function automatic logic in_protect(input logic [4:0] bp,
                                      input logic cmp,
                                      input logic [20:0] a);
    logic       hit;
    logic [4:0] blk;
    logic [2:0] sec;
    blk = a[20:16];
    sec = a[15:13];
    hit = 1'b0;
    if (bp[2:0] == 3'b000)
      hit = 1'b0;
    else if (bp[2:1] == 2'b11)
      hit = 1'b1;
    else if (!bp[4]) begin
      // 64KB fractions: code n protects 2^(n-1) blocks at one end
      // at the top of the array, or at the bottom when bit 3 is set
      logic [4:0] n_blk;
      n_blk = 5'(1 << (bp[2:0] - 3'd1));
      if (!bp[3]) hit = (blk >= 5'(32 - n_blk));
      else        hit = (blk < n_blk);
    end else begin
      // 4-32KB end regions, 32KB when low bits are 10x
      // a4k numbers the 4KB sectors inside the end block
      logic [3:0] n_sec;
      logic [3:0] a4k;
      n_sec = bp[2] ? 4'd8 : 4'(1 << (bp[1:0] - 2'd1));
      a4k   = {sec, a[12]};
      if (!bp[3]) hit = (blk == 5'h1F) && (a4k >= 4'(16 - n_sec));
      else        hit = (blk == 5'h00) && (a4k < n_sec);
    end
    in_protect = cmp ? !hit : hit;
  endfunction

  // Status and busy state. The counter is 16 bits wide, which bounds
  // BUSY_CYC; the power-up load flag marks the first edge after reset
  logic [15:0]          sr_r, sr_nxt;
  flash_sr_pkg::state_t st_r, st_nxt;
  logic [15:0]          cnt_r, cnt_nxt;
  logic                 pwr_load_r, pwr_load_nxt;
  logic                 acc_r, acc_nxt, rej_r, rej_nxt, go_r, go_nxt;
  logic                 nvs_r, nvs_nxt;

  // Fields of the current status word and the decisions drawn from them
  logic [4:0] bp;
  logic [1:0] spm;
  logic       write_enable_latch, cmp, sr_locked, hw_pin_low, prot_hit, ok;
  logic [15:0] wr_val;

  always_comb begin
    bp         = sr_r[`SR_BP_LSB +: 5];
    spm        = sr_r[`SR_SPM_LSB +: 2];
    write_enable_latch        = sr_r[`SR_WEL_BIT];
    cmp        = sr_r[`SR_CMP_BIT];
    // With quad enabled the pin is a data line, not write protect
    hw_pin_low = !wp_sync_r[1] && !sr_r[`SR_QE_BIT];
    prot_hit   = in_protect(bp, cmp, cmd_addr[20:0]);
    // The pin bars status writes only in mode 01; modes 10 and 11 bar
    // them whatever the pin does
    sr_locked  = (spm == `SPM_HW && hw_pin_low)
              || (spm == `SPM_LOCKDOWN)
              || (spm == `SPM_OTP);
    // Only writable bits follow the data; the lock bit can only be set
    wr_val = (sr_r & ~16'(`SR_WMASK)) | (cmd_data & 16'(`SR_WMASK));
    wr_val[`SR_LB_BIT] = sr_r[`SR_LB_BIT] | cmd_data[`SR_LB_BIT];

    // Defaults: state holds, every answer pulse drops back to zero
    sr_nxt       = sr_r;
    st_nxt       = st_r;
    cnt_nxt      = cnt_r;
    pwr_load_nxt = 1'b0;
    acc_nxt      = 1'b0;
    rej_nxt      = 1'b0;
    go_nxt       = 1'b0;
    nvs_nxt      = 1'b0;
    ok           = 1'b0;

    if (pwr_load_r) begin
      // Power-up load: latch clear, lockdown mode falls back to 00
      // The load raises no store strobe, so mode 10 stays in the image; every later load turns it to 00 again
      sr_nxt = nv_image & 16'(`SR_WMASK);
      sr_nxt[`SR_WEL_BIT] = 1'b0;
      if (nv_image[`SR_SPM_LSB +: 2] == `SPM_LOCKDOWN)
        sr_nxt[`SR_SPM_LSB +: 2] = `SPM_SOFT;
    end else begin
      case (st_r)
        flash_sr_pkg::ST_IDLE: begin
          if (cmd_valid) begin
            case (cmd_code)
              // Latch set and clear never touch the busy state
              flash_sr_pkg::CMD_WREN: begin
                ok = 1'b1;
                sr_nxt[`SR_WEL_BIT] = 1'b1;
              end
              flash_sr_pkg::CMD_WRDI: begin
                ok = 1'b1;
                sr_nxt[`SR_WEL_BIT] = 1'b0;
              end
              flash_sr_pkg::CMD_WRSTAT: begin
                // The latch stays set through the busy phase and is
                // cleared when the write completes
                ok = write_enable_latch && !sr_locked;
                if (ok) begin
                  sr_nxt = wr_val;
                  nvs_nxt = 1'b1;
                end
              end
              flash_sr_pkg::CMD_PROG, flash_sr_pkg::CMD_SECT,
              flash_sr_pkg::CMD_BLOCK:
                ok = write_enable_latch && !prot_hit;
              flash_sr_pkg::CMD_QPROG:
                ok = write_enable_latch && !prot_hit && sr_r[`SR_QE_BIT];
              // Whole-array clear ignores bits 4 and 3 of the protect field
              flash_sr_pkg::CMD_CHIP:
                ok = write_enable_latch && bp[2:0] == 3'b000 && !cmp;
              // Quad reads never go busy; they only need the quad enable bit
              flash_sr_pkg::CMD_QREAD:
                ok = sr_r[`SR_QE_BIT];
              default: ok = 1'b0;
            endcase
            // Exactly one answer per command, one cycle later
            acc_nxt = ok;
            rej_nxt = !ok;
            // Status writes and array operations both start the busy phase;
            // only the array ones are handed on to the array sequencer
            if (ok && cmd_code inside {flash_sr_pkg::CMD_WRSTAT,
                flash_sr_pkg::CMD_PROG, flash_sr_pkg::CMD_QPROG,
                flash_sr_pkg::CMD_SECT, flash_sr_pkg::CMD_BLOCK,
                flash_sr_pkg::CMD_CHIP}) begin
              go_nxt  = (cmd_code != flash_sr_pkg::CMD_WRSTAT);
              sr_nxt[`SR_WIP_BIT] = 1'b1;
              st_nxt  = flash_sr_pkg::ST_BUSY;
              cnt_nxt = 16'(BUSY_CYC - 1);
            end
          end
        end
        flash_sr_pkg::ST_BUSY: begin
          // Commands during busy are all refused, quad reads included
          if (cmd_valid) rej_nxt = 1'b1;
          // The counter starts at BUSY_CYC-1, so the busy bit stands for
          // exactly BUSY_CYC cycles
          if (cnt_r == 16'h0000) begin
            sr_nxt[`SR_WIP_BIT] = 1'b0;
            sr_nxt[`SR_WEL_BIT] = 1'b0;
            st_nxt = flash_sr_pkg::ST_IDLE;
          end else begin
            cnt_nxt = cnt_r - 16'h0001;
          end
        end
        default: st_nxt = flash_sr_pkg::ST_IDLE;
      endcase
    end
    // Status flags owned by other logic are mirrored live
    // They come from logic on this clock, so no synchroniser is needed
    sr_nxt[`SR_HPF_BIT] = high_perf_in;
    sr_nxt[`SR_SUS_BIT] = op_paused_in;
    sr_nxt[12:11]       = 2'b00;
  end

  // State registers. Reset stands for a power cycle: the next edge loads
  // the non-volatile image, so commands in that cycle get no answer
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sr_r       <= `SR_RESET;
      st_r       <= flash_sr_pkg::ST_IDLE;
      cnt_r      <= 16'h0000;
      pwr_load_r <= 1'b1;
      acc_r      <= 1'b0;
      rej_r      <= 1'b0;
      go_r       <= 1'b0;
      nvs_r      <= 1'b0;
    end else begin
      sr_r       <= sr_nxt;
      st_r       <= st_nxt;
      cnt_r      <= cnt_nxt;
      pwr_load_r <= pwr_load_nxt;
      acc_r      <= acc_nxt;
      rej_r      <= rej_nxt;
      go_r       <= go_nxt;
      nvs_r      <= nvs_nxt;
    end
  end

  // Registered outputs. The store image follows the next status value on
  // every edge, so it is already valid when the store strobe rises
  logic        lrise_r;
  logic [15:0] nvw_r;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      lrise_r <= 1'b0;
      nvw_r   <= 16'h0000;
    end else begin
      // Edge detect reads only the second and third link stages
      lrise_r <= lclk_sync_r[1] && !lclk_sync_r[2];
      nvw_r   <= sr_nxt & 16'(`SR_WMASK);
    end
  end

  // Ports come straight from the registers above; no logic sits between
  always_comb begin
    status_word    = sr_r;
    cmd_accepted   = acc_r;
    cmd_rejected   = rej_r;
    array_op_start = go_r;
    quad_mode      = sr_r[`SR_QE_BIT];
    security_ro    = sr_r[`SR_LB_BIT];
    link_clk_rise  = lrise_r;
    nv_store       = nvw_r;
    nv_store_en    = nvs_r;
  end

endmodule // flash_status_write_protect

// ==== rtl/flash_sr_cfg.svh ====
// Status word layout, protect codes and timing counts for the flash
// status and write-protect block. Definitions only.
`ifndef FLASH_SR_CFG_SVH
`define FLASH_SR_CFG_SVH
`define SR_WIP_BIT      0
`define SR_WEL_BIT      1
`define SR_BP_LSB       2
`define SR_SPM_LSB      7
`define SR_QE_BIT       9
`define SR_LB_BIT       10
`define SR_HPF_BIT      13
`define SR_CMP_BIT      14
`define SR_SUS_BIT      15
// Bits software may write: BP, mode, QE, LB, CMP (not 0,1,11,12,13,15)
`define SR_WMASK        16'h47_FC
`define SR_RESET        16'h0000
`define SPM_SOFT        2'b00
`define SPM_HW          2'b01
`define SPM_LOCKDOWN    2'b10
`define SPM_OTP         2'b11
`define OP_BUSY_NS      1000
`define SYS_PERIOD_NS   20
`define OP_BUSY_CYC     ((`OP_BUSY_NS + `SYS_PERIOD_NS - 1) / `SYS_PERIOD_NS)
`define BLK64_SHIFT     16
`define SEC4_SHIFT      12
`endif

// ==== rtl/flash_sr_pkg.sv ====
// Types for the flash status and write-protect block.
// Assumes the cfg header supplies every number.
package flash_sr_pkg;
  typedef enum logic [3:0] {
    CMD_NONE    = 4'h0,
    CMD_WREN    = 4'h1,
    CMD_WRDI    = 4'h2,
    CMD_WRSTAT  = 4'h3,
    CMD_PROG    = 4'h4,
    CMD_QPROG   = 4'h5,
    CMD_SECT    = 4'h6,
    CMD_BLOCK   = 4'h7,
    CMD_CHIP    = 4'h8,
    CMD_QREAD   = 4'h9
  } cmd_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } state_t;
endpackage

// ==== testbench/flash_sr_checker.sv ====
// Port assertions for the flash status and write-protect block.
// Assumes one clk_sys domain; resetn low stands for a power cycle.
`timescale 1ns/1ps
module flash_sr_checker (
  // Clock and reset
  input wire logic               clk_sys,
  input wire logic               resetn,
  // Command side
  input wire logic               cmd_valid,
  input wire flash_sr_pkg::cmd_t cmd_code,
  input wire logic               link_clk,
  // Results
  input wire logic [15:0]        status_word,
  input wire logic               cmd_accepted,
  input wire logic               cmd_rejected,
  input wire logic               array_op_start,
  input wire logic               nv_store_en,
  input wire logic               security_ro,
  input wire logic               link_clk_rise
);
  // One domain, so clock and disable are shared
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  // Load cycle is excluded: commands there are dropped on purpose
  a_one_answer: assert property (
    cmd_valid && $past(resetn) |=> cmd_accepted ^ cmd_rejected)
    else $error("command not answered exactly once");
  a_latch_refuse: assert property (
    cmd_valid && !$past(cmd_valid) && !status_word[1] &&
    cmd_code >= 4'h3 && cmd_code <= 4'h8 |=> cmd_rejected)
    else $error("write command taken with latch clear");
  a_busy_refuse: assert property (cmd_valid && status_word[0] |=>
    cmd_rejected) else $error("command taken while busy");
  a_busy_start: assert property (array_op_start |->
    status_word[0] && cmd_accepted) else $error("busy flag not raised");
  a_busy_bound: assert property (status_word[0] |->
    ##[1:12] !status_word[0]) else $error("busy flag stuck");
  a_latch_done: assert property ($fell(status_word[0]) |->
    !status_word[1]) else $error("latch left set after operation");
  a_chip_guard: assert property (
    cmd_valid && cmd_code == flash_sr_pkg::CMD_CHIP &&
    (status_word[4:2] != 3'h0 || status_word[14]) |=> cmd_rejected)
    else $error("whole array clear taken while guarded");
  a_quad_guard: assert property (cmd_valid && !status_word[9] &&
    (cmd_code == flash_sr_pkg::CMD_QPROG ||
     cmd_code == flash_sr_pkg::CMD_QREAD) |=> cmd_rejected)
    else $error("quad command taken with quad enable clear");
  a_mode_lock: assert property (cmd_valid && status_word[8] &&
    cmd_code == flash_sr_pkg::CMD_WRSTAT |=> cmd_rejected)
    else $error("status write taken in locked mode");
  a_lock_sticky: assert property (status_word[10] |=> status_word[10] &&
    security_ro) else $error("security lock cleared");
  a_reserved_zero: assert property (status_word[12:11] == 2'h0)
    else $error("reserved status bits not zero");
  a_store_pulse: assert property (cmd_accepted &&
    $past(cmd_code) == flash_sr_pkg::CMD_WRSTAT |-> nv_store_en)
    else $error("accepted status write not stored");
  a_op_start: assert property (cmd_accepted &&
    $past(cmd_code) inside {flash_sr_pkg::CMD_PROG,
    flash_sr_pkg::CMD_QPROG, flash_sr_pkg::CMD_SECT,
    flash_sr_pkg::CMD_BLOCK, flash_sr_pkg::CMD_CHIP} |-> array_op_start)
    else $error("accepted array operation not started");
  a_link_edge: assert property ($rose(link_clk) |-> ##[1:5] link_clk_rise)
    else $error("serial clock edge not reported");
  // Main scenarios reached
  c_array_op: cover property (array_op_start);
  c_refused: cover property (cmd_rejected && status_word[8]);
  c_stored: cover property (nv_store_en);
endmodule // flash_sr_checker

bind flash_status_write_protect flash_sr_checker i_chk (
  .clk_sys(clk_sys), .resetn(resetn), .cmd_valid(cmd_valid),
  .cmd_code(cmd_code), .link_clk(link_clk), .status_word(status_word),
  .cmd_accepted(cmd_accepted), .cmd_rejected(cmd_rejected),
  .array_op_start(array_op_start), .nv_store_en(nv_store_en),
  .security_ro(security_ro), .link_clk_rise(link_clk_rise));

// ==== testbench/flash_host_model.sv ====
// Host model handing decoded flash commands to the block.
// Assumes clk_sys is the block clock; the bench calls send().
`timescale 1ns/1ps
module flash_host_model #(
  parameter int ADDR_W = 21
) (
  // Clock
  input wire logic           clk_sys,
  // Command lines
  output logic               cmd_valid,
  output flash_sr_pkg::cmd_t cmd_code,
  output logic [ADDR_W-1:0]  cmd_addr,
  output logic [15:0]        cmd_data,
  // Serial clock, still outside frames
  output logic               link_clk
);
  // Pins are driven, never tied, so quad enable may be set
  initial begin
    cmd_valid = 1'b0;
    cmd_code = flash_sr_pkg::CMD_NONE;
    cmd_addr = '0;
    cmd_data = 16'h0000;
    link_clk = 1'b0;
  end
  // Frame: serial clocks, then a one-cycle command; quick skips clocks
  task automatic send(input flash_sr_pkg::cmd_t c,
    input logic [ADDR_W-1:0] a, input logic [15:0] d, input bit quick);
    if (!quick) begin
      repeat (2) begin
        #7 link_clk = 1'b1;
        #80 link_clk = 1'b0;
        #73;
      end
    end
    @(negedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_addr <= a;
    cmd_data <= d;
    @(negedge clk_sys);
    cmd_valid <= 1'b0;
    cmd_code <= flash_sr_pkg::CMD_NONE;
    // Released lines do not keep their last value
    cmd_addr <= ~a;
    cmd_data <= ~d;
  endtask
endmodule // flash_host_model

// ==== testbench/tb_top.sv ====
// Self-checking bench for the flash status and write-protect block.
// Assumes the host model drives commands; the bench keeps the nv image.
`timescale 1ns/1ps
`include "flash_sr_cfg.svh"
module tb_top;
  typedef struct packed {
    logic        pin;
    logic [15:0] sr;
    logic [3:0]  code;
    logic [20:0] addr;
    logic        acc;
  } prot_case_t;
  logic clk_sys = 1'b0, resetn = 1'b0, wp_pin = 1'b1;
  logic high_perf_in = 1'b0, op_paused_in = 1'b0, link_clk, cmd_valid;
  logic [15:0] nv_image = `SR_RESET, nv_store, cmd_data, status_word;
  logic [20:0] cmd_addr;
  logic [31:0] seed = 32'h04c2, rnd;
  logic nv_store_en, cmd_accepted, cmd_rejected, array_op_start;
  logic quad_mode, security_ro, link_clk_rise;
  flash_sr_pkg::cmd_t cmd_code;
  logic exp_q [$];
  int fail_count = 0, total_checks = 0;
  // Pin, setup word, command, target, expected acceptance
  prot_case_t tbl [23] = '{
    '{1'b1, 16'h0007, 4'h4, 21'h1F_0000, 1'b0},
    '{1'b1, 16'h1804, 4'h6, 21'h1E_FFFF, 1'b1},
    '{1'b1, 16'h0024, 4'h7, 21'h00_FFFF, 1'b0},
    '{1'b1, 16'h0044, 4'h4, 21'h1F_F000, 1'b0},
    '{1'b1, 16'h0044, 4'h4, 21'h1F_EFFF, 1'b1},
    '{1'b1, 16'h0064, 4'h6, 21'h00_0FFF, 1'b0},
    '{1'b1, 16'h0018, 4'h4, 21'h00_0000, 1'b0},
    '{1'b1, 16'h4000, 4'h4, 21'h12_3456, 1'b0},
    '{1'b1, 16'h4004, 4'h4, 21'h1E_FFFF, 1'b0},
    '{1'b1, 16'h4004, 4'h4, 21'h1F_0000, 1'b1},
    '{1'b1, 16'h4064, 4'h6, 21'h00_1000, 1'b0},
    '{1'b1, 16'h4064, 4'h6, 21'h00_0FFF, 1'b1},
    '{1'b1, 16'h4018, 4'h7, 21'h00_0000, 1'b1},
    '{1'b1, 16'h0060, 4'h8, 21'h00_0000, 1'b1},
    '{1'b1, 16'h0004, 4'h8, 21'h00_0000, 1'b0},
    '{1'b1, 16'h4000, 4'h8, 21'h00_0000, 1'b0},
    '{1'b1, 16'h0000, 4'h9, 21'h00_0000, 1'b0},
    '{1'b1, 16'h0200, 4'h5, 21'h00_0000, 1'b1},
    '{1'b1, 16'h0200, 4'h9, 21'h00_0000, 1'b1},
    '{1'b0, 16'h0080, 4'h3, 21'h00_0000, 1'b0},
    '{1'b1, 16'h0080, 4'h3, 21'h00_0000, 1'b1},
    '{1'b0, 16'h0000, 4'h3, 21'h00_0000, 1'b1},
    '{1'b1, 16'h0500, 4'h3, 21'h00_0000, 1'b0}};

  flash_status_write_protect #(.ADDR_W(21), .BUSY_CYC(3)) i_dut (
    .clk_sys(clk_sys), .resetn(resetn), .nv_image(nv_image),
    .nv_store(nv_store), .nv_store_en(nv_store_en),
    .write_protect_pin_in(wp_pin), .link_clk(link_clk),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .high_perf_in(high_perf_in),
    .op_paused_in(op_paused_in), .status_word(status_word),
    .cmd_accepted(cmd_accepted), .cmd_rejected(cmd_rejected),
    .array_op_start(array_op_start), .quad_mode(quad_mode),
    .security_ro(security_ro), .link_clk_rise(link_clk_rise));
  flash_host_model #(.ADDR_W(21)) i_host (.clk_sys(clk_sys),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .link_clk(link_clk));

  always #10 clk_sys = ~clk_sys;
  // Non-volatile store survives resets, like the cells it stands for
  always @(posedge clk_sys) if (nv_store_en) nv_image <= nv_store;
  // Random mirrored levels, changed off the sampling edge
  always @(negedge clk_sys) begin
    rnd = $random(seed);
    high_perf_in <= rnd[0];
    op_paused_in <= rnd[1];
  end
  // Answers stand one cycle, so mid-cycle sampling sees each once
  always @(negedge clk_sys) if (cmd_accepted || cmd_rejected) begin
    if (exp_q.size() == 0) check(16'h0001, 16'h0000);
    else check(16'(cmd_accepted), 16'(exp_q.pop_front()));
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    total_checks++;
    if (seen !== want) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic stop_test();
    if (fail_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic power_cycle();
    resetn = 1'b0;
    repeat (16) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (3) @(negedge clk_sys);
  endtask
  // One command; probe adds a second one inside the busy window
  task automatic op(input logic [3:0] c, input logic [20:0] a,
    input logic [15:0] d, input logic e, input bit probe);
    int n;
    n = 0;
    exp_q.push_back(e);
    i_host.send(flash_sr_pkg::cmd_t'(c), a, d, 1'b0);
    if (probe) begin
      exp_q.push_back(1'b0);
      i_host.send(flash_sr_pkg::CMD_WREN, 21'h00_0000, 16'h0000, 1'b1);
    end
    repeat (2) @(negedge clk_sys);
    while (status_word[0] !== 1'b0 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 40) check(16'h0001, 16'h0000);
  endtask
  task automatic set_sr(input logic [15:0] d, input logic e);
    op(4'h1, 21'h00_0000, 16'h0000, 1'b1, 1'b0);
    op(4'h3, 21'h00_0000, d, e, 1'b0);
  endtask

  // Main sequence
  initial begin
    power_cycle();
    op(4'h4, 21'h00_0000, 16'h0000, 1'b0, 1'b0);
    op(4'h3, 21'h00_0000, 16'h0000, 1'b0, 1'b0);
    foreach (tbl[k]) begin
      wp_pin = 1'b1;
      set_sr(tbl[k].sr, 1'b1);
      check(status_word & 16'h5FFF, tbl[k].sr & `SR_WMASK);
      check(16'(quad_mode), 16'(tbl[k].sr[`SR_QE_BIT]));
      check(16'(security_ro), 16'(tbl[k].sr[`SR_LB_BIT]));
      wp_pin = tbl[k].pin;
      repeat (4) @(negedge clk_sys);
      op(4'h1, 21'h00_0000, 16'h0000, 1'b1, 1'b0);
      op(tbl[k].code, tbl[k].addr, 16'h0000, tbl[k].acc, k == 1);
    end
    op(4'h2, 21'h00_0000, 16'h0000, 1'b1, 1'b0);
    check(status_word & 16'h0002, 16'h0000);
    power_cycle();
    check(status_word & 16'h5FFF, 16'h0400);
    check(16'(security_ro), 16'h0001);
    set_sr(16'h0180, 1'b1);
    check(status_word & 16'h5FFF, 16'h0580);
    power_cycle();
    check(status_word & 16'h5FFF, 16'h0580);
    set_sr(16'h0000, 1'b0);
    check(16'(exp_q.size()), 16'h0000);
    stop_test();
  end
  // Cuts a hang short
  initial begin
    #400_000;
    fail_count++;
    stop_test();
  end
endmodule // tb_top
